// File: common/sbsa_pkg.sv
// constants and types shared by the serial bus software access block
// assumes one clock (MCLK) and a byte wide configuration access port
//
// Operation
// [RULE1] data register: byte to send, byte received
// [RULE2] word address register sent as address byte
// [RULE3] word address unused in quick command format
// [RULE4] bit 7 protocol select drops address phase
// [RULE5] only target register write starts transfer
// [RULE6] target register holds address and direction
// [RULE7] control status: present, busy, error, controls
// [RULE8] software checks present and both busy flags
// [RULE9] software loads word and data before target
// [RULE10] target write is third step, launches transfer
// [RULE11] request busy held until transaction ends
// [RULE12] error checked after busy; read data valid
// [RULE13] missing acknowledge sets serial error bit 1
// [RULE14] protocol select omits word address and ack; code omits word address and restart but still checks ack
// [RULE15] write: start, addr+0, word, data, stop
// [RULE16] read: word, restart, addr+1, byte, nack, stop
// [RULE17] busy from next cycle until stop driven
package sbsa_pkg;

   ////////////////////////////////////////////////////////////////////////
   // register offsets
   localparam logic [7:0] OFS_DATA   = 8'hb0;
   localparam logic [7:0] OFS_WORD   = 8'hb1;
   localparam logic [7:0] OFS_TARGET = 8'hb2;
   localparam logic [7:0] OFS_CTRL   = 8'hb3;

   // control and status bit positions
   localparam int CS_PROTOCOL_SELECT = 7;
   localparam int CS_REQ_BUSY = 5;
   localparam int CS_DL_BUSY  = 4;
   localparam int CS_PRESENT  = 3;
   localparam int CS_TEST     = 2;
   localparam int CS_ERR      = 1;
   localparam int CS_DL_ERR   = 0;

   // target select: direction in bit 0, address above
   localparam int TGT_RW = 0;

   // reset values
   localparam logic [7:0] DATA_RST     = 8'h00;
   localparam logic [7:0] WORD_RST     = 8'h00;
   localparam logic [7:0] TARGET_RST   = 8'h00;
   localparam logic       PROTOCOL_SELECT_RST = 1'b0;
   localparam logic       TEST_RST     = 1'b0;

   ////////////////////////////////////////////////////////////////////////
   // timing: least serial clock period, rounded up to whole cycles
   localparam int MCLK_PERIOD_NS = 40;
   localparam int SCL_PERIOD_NS  = 320;
   localparam int BIT_CYCLES     =
      (SCL_PERIOD_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
   typedef logic [3:0] sbsa_cnt_t;
   localparam sbsa_cnt_t QTR_CYCLES =
      sbsa_cnt_t'((BIT_CYCLES >= 4) ? BIT_CYCLES / 4 : 1);

   ////////////////////////////////////////////////////////////////////////
   // types
   typedef enum logic [1:0] {B_START, B_STOP, B_WBIT, B_RBIT} sbsa_bcmd_e;

   typedef struct packed {
      logic       go;
      sbsa_bcmd_e kind;
      logic       wbit;
   } sbsa_cmd_s;

   typedef struct packed {
      logic done;
      logic rx;
   } sbsa_rsp_s;

   typedef enum logic [2:0] {
      ST_IDLE, ST_START, ST_TXBYTE, ST_TXACK,
      ST_RSTART, ST_RXBYTE, ST_RXNACK, ST_STOP
   } sbsa_step_e;

   typedef enum logic [1:0] {BY_ADDR, BY_WORD, BY_DATA, BY_RADDR} sbsa_byte_e;

   typedef struct packed {
      logic       busy;
      sbsa_bcmd_e kind;
      logic       wbit;
      logic [1:0] qtr;
      sbsa_cnt_t  cnt;
      logic       scl_hi;
      logic       sda_hi;
      logic       sda_meta;
      logic       sda_sync;
      logic       rx;
      logic       done;
   } sbsa_eng_s;

   typedef struct packed {
      logic [7:0] data;
      logic [7:0] word;
      logic [7:0] target;
      logic       protocol_select;
      logic       test_mode;
      logic       err;
      logic       busy;
      logic       present_meta;
      logic       present_sync;
      sbsa_step_e step;
      sbsa_byte_e stage;
      logic [7:0] shreg;
      logic [2:0] bitcnt;
      logic       pend;
      sbsa_cmd_s  cmd;
      logic [7:0] rdata;
      logic       rvalid;
      logic       line_lvl;
   } sbsa_top_s;

   localparam sbsa_eng_s ENG_RST = '{
      busy: 1'b0, kind: B_START, wbit: 1'b0, qtr: 2'h0, cnt: 4'h0,
      scl_hi: 1'b1, sda_hi: 1'b1, sda_meta: 1'b1, sda_sync: 1'b1,
      rx: 1'b1, done: 1'b0};

   localparam sbsa_top_s TOP_RST = '{
      data: DATA_RST, word: WORD_RST, target: TARGET_RST,
      protocol_select: PROTOCOL_SELECT_RST, test_mode: TEST_RST, err: 1'b0,
      busy: 1'b0, present_meta: 1'b0, present_sync: 1'b0,
      step: ST_IDLE, stage: BY_ADDR, shreg: 8'h00, bitcnt: 3'h0,
      pend: 1'b0, cmd: '{go: 1'b0, kind: B_START, wbit: 1'b0},
      rdata: 8'h00, rvalid: 1'b0, line_lvl: 1'b0};

endpackage : sbsa_pkg

// File: rtl/sbsa_bit_engine.sv
// bit level engine: start, stop, write bit, read bit on the two wires
// assumes open-drain lines pulled high outside; no clock stretching
`timescale 1ns/1ns
module sbsa_bit_engine
   import sbsa_pkg::*;
(
   // clock and reset
   input  wire logic      mclk,
   input  wire logic      reset_n,
   // command from the byte sequencer
   input  wire sbsa_cmd_s cmd,
   output sbsa_rsp_s      rsp,
   // line controls, enable low pulls the line low
   input  wire logic      sda_in,
   output logic           sda_oe_n,
   output logic           scl_oe_n
);

   sbsa_eng_s r;
   sbsa_eng_s n;

   ////////////////////////////////////////////////////////////////////////
   // line levels {scl, sda} for each quarter of a bit
   function automatic logic [1:0] line_lv(sbsa_bcmd_e k, logic b,
                                          logic [1:0] q);
      logic mid;
      logic [1:0] lv;
      mid = (q == 2'h1) || (q == 2'h2);
      lv  = 2'h3;
      unique case (k)
         B_START: lv = {mid, (q < 2'h2)};
         B_STOP:  lv = {(q != 2'h0), (q >= 2'h2)};
         B_WBIT:  lv = {mid, b};
         B_RBIT:  lv = {mid, 1'b1};
      endcase
      return lv;
   endfunction : line_lv

   ////////////////////////////////////////////////////////////////////////
   always_comb begin
      n          = r;
      n.sda_meta = sda_in;
      n.sda_sync = r.sda_meta;
      n.done     = 1'b0;
      if (!r.busy) begin
         if (cmd.go) begin
            n.busy = 1'b1;
            n.kind = cmd.kind;
            n.wbit = cmd.wbit;
            n.qtr  = 2'h0;
            n.cnt  = QTR_CYCLES - 4'h1;
            {n.scl_hi, n.sda_hi} = line_lv(cmd.kind, cmd.wbit, 2'h0);
         end
      end else if (r.cnt != 4'h0) begin
         n.cnt = r.cnt - 4'h1;
      end else if (r.qtr == 2'h3) begin
         // levels stay put so the next bit starts from them
         n.busy = 1'b0;
         n.done = 1'b1;
      end else begin
         n.cnt = QTR_CYCLES - 4'h1;
         n.qtr = r.qtr + 2'h1;
         // sample late in the high phase, after the synchroniser delay
         if (r.qtr == 2'h2 && r.kind == B_RBIT) begin
            n.rx = r.sda_sync;
         end
         {n.scl_hi, n.sda_hi} = line_lv(r.kind, r.wbit, n.qtr);
      end
   end

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         r <= ENG_RST;
      end else begin
         r <= n;
      end
   end

   assign rsp.done = r.done;
   assign rsp.rx   = r.rx;
   assign sda_oe_n = r.sda_hi;
   assign scl_oe_n = r.scl_hi;

endmodule : sbsa_bit_engine

// File: rtl/sbsa_top.sv
// serial bus software access: four byte registers and byte sequencer
// assumes config accesses arrive as one-cycle strobes on MCLK
`timescale 1ns/1ns
module sbsa_top
   import sbsa_pkg::*;
(
   // clock and reset
   input  wire logic       MCLK,
   input  wire logic       RESET_N,
   // configuration byte access
   input  wire logic [7:0] CFG_ADDR,
   input  wire logic       CFG_WR,
   input  wire logic [7:0] CFG_WDATA,
   input  wire logic       CFG_RD,
   output logic [7:0]      CFG_RDATA,
   output logic            CFG_RVALID,
   // status from the rest of the chip
   input  wire logic       INTERFACE_PRESENT,
   input  wire logic       DOWNLOAD_BUSY,
   output logic            SERIAL_TEST_MODE,
   // serial data line
   input  wire logic       SDA_IN,
   output logic            SDA_OUT,
   output logic            SDA_OE_N,
   // serial clock line
   output logic            SCL_OUT,
   output logic            SCL_OE_N
);

   sbsa_top_s r;
   sbsa_top_s n;
   sbsa_rsp_s rsp;
   logic      rd_dir;
   logic      wr_ok;
   logic [7:0] cs_byte;

   ////////////////////////////////////////////////////////////////////////
   // bit engine

   sbsa_bit_engine u_eng (
      .mclk     (MCLK),
      .reset_n  (RESET_N),
      .cmd      (r.cmd),
      .rsp      (rsp),
      .sda_in   (SDA_IN),
      .sda_oe_n (SDA_OE_N),
      .scl_oe_n (SCL_OE_N)
   );

   ////////////////////////////////////////////////////////////////////////
   // control and status byte as software sees it

   always_comb begin
      cs_byte              = 8'h00;
      cs_byte[CS_PROTOCOL_SELECT] = r.protocol_select;                 // see [RULE4]
      cs_byte[CS_REQ_BUSY] = r.busy;                     // see [RULE7]
      cs_byte[CS_DL_BUSY]  = DOWNLOAD_BUSY;              // see [RULE7]
      cs_byte[CS_PRESENT]  = r.present_sync;             // see [RULE7]
      cs_byte[CS_TEST]     = r.test_mode;                // see [RULE7]
      cs_byte[CS_ERR]      = r.err;                      // see [RULE13]
      cs_byte[CS_DL_ERR]   = 1'b0;
   end

   // direction of the current transfer
   assign rd_dir = r.target[TGT_RW];                     // see [RULE6]

   // a transfer in flight freezes the setup registers, so a late
   // write cannot corrupt the bytes already being shifted
   assign wr_ok = CFG_WR && !r.busy;                     // see [RULE8]

   ////////////////////////////////////////////////////////////////////////
   // registers and sequencer

   always_comb begin
      n              = r;
      n.present_meta = INTERFACE_PRESENT;
      n.present_sync = r.present_meta;
      n.cmd.go       = 1'b0;
      n.rvalid       = 1'b0;

      // read port answers the cycle after the strobe
      if (CFG_RD) begin
         n.rvalid = 1'b1;
         unique case (CFG_ADDR)
            OFS_DATA:   n.rdata = r.data;                // see [RULE1]
            OFS_WORD:   n.rdata = r.word;
            OFS_TARGET: n.rdata = r.target;
            OFS_CTRL:   n.rdata = cs_byte;
            default:    n.rdata = 8'h00;
         endcase
      end

      // error flag is write one to clear; a set below still wins
      if (CFG_WR && CFG_ADDR == OFS_CTRL && CFG_WDATA[CS_ERR]) begin
         n.err = 1'b0;
      end

      if (wr_ok) begin
         unique case (CFG_ADDR)
            OFS_DATA: begin
               n.data = CFG_WDATA;                       // see [RULE9]
            end
            OFS_WORD: begin
               n.word = CFG_WDATA;                       // see [RULE9]
            end
            OFS_CTRL: begin
               n.protocol_select  = CFG_WDATA[CS_PROTOCOL_SELECT];     // see [RULE4]
               n.test_mode = CFG_WDATA[CS_TEST];         // see [RULE7]
            end
            OFS_TARGET: begin
               // a download owns the wires, so the start is refused
               if (!DOWNLOAD_BUSY) begin
                  n.target = CFG_WDATA;                  // see [RULE6]
                  n.busy   = 1'b1;                       // see [RULE17]
                  n.err    = 1'b0;
                  n.step   = ST_START;                   // see [RULE5]
                  n.pend   = 1'b0;
                  n.bitcnt = 3'h0;
               end
            end
            default: begin
            end
         endcase
      end

      // each step issues one bit command, then waits for its done
      if (r.step != ST_IDLE && !r.pend) begin
         n.pend   = 1'b1;
         n.cmd.go = 1'b1;
         unique case (r.step)
            ST_START, ST_RSTART: begin
               n.cmd.kind = B_START;
               n.cmd.wbit = 1'b1;
            end
            ST_TXBYTE: begin
               n.cmd.kind = B_WBIT;                      // see [RULE15]
               n.cmd.wbit = r.shreg[7];
            end
            ST_TXACK, ST_RXBYTE: begin
               n.cmd.kind = B_RBIT;
               n.cmd.wbit = 1'b1;
            end
            ST_RXNACK: begin
               n.cmd.kind = B_WBIT;                      // see [RULE16]
               n.cmd.wbit = 1'b1;
            end
            ST_STOP: begin
               n.cmd.kind = B_STOP;
               n.cmd.wbit = 1'b1;
            end
            ST_IDLE: begin
               n.pend   = 1'b0;
               n.cmd.go = 1'b0;
            end
         endcase
      end

      if (r.pend && rsp.done) begin
         n.pend = 1'b0;
         unique case (r.step)
            ST_START: begin
               n.bitcnt = 3'h0;
               n.step   = ST_TXBYTE;
               // the alternative read goes straight to the read address
               if (r.protocol_select && rd_dir) begin           // see [RULE14]
                  n.stage = BY_RADDR;
                  n.shreg = {r.target[7:1], 1'b1};
               end else begin
                  n.stage = BY_ADDR;
                  n.shreg = {r.target[7:1], 1'b0};       // see [RULE15]
               end
            end
            ST_RSTART: begin
               n.bitcnt = 3'h0;
               n.step   = ST_TXBYTE;
               n.stage  = BY_RADDR;
               n.shreg  = {r.target[7:1], 1'b1};         // see [RULE16]
            end
            ST_TXBYTE: begin
               n.shreg  = {r.shreg[6:0], 1'b0};          // see [RULE15]
               n.bitcnt = r.bitcnt + 3'h1;
               if (r.bitcnt == 3'h7) begin
                  n.step = ST_TXACK;
               end
            end
            ST_TXACK: begin
               n.bitcnt = 3'h0;
               if (rsp.rx) begin
                  n.err  = 1'b1;                         // see [RULE13]
                  n.step = ST_STOP;
               end else begin
                  unique case (r.stage)
                     BY_ADDR: begin
                        n.step = ST_TXBYTE;
                        if (r.protocol_select) begin            // see [RULE3]
                           n.stage = BY_DATA;            // see [RULE14]
                           n.shreg = r.data;             // see [RULE1]
                        end else begin
                           n.stage = BY_WORD;
                           n.shreg = r.word;             // see [RULE2]
                        end
                     end
                     BY_WORD: begin
                        if (rd_dir) begin
                           n.step = ST_RSTART;           // see [RULE16]
                        end else begin
                           n.step  = ST_TXBYTE;
                           n.stage = BY_DATA;
                           n.shreg = r.data;             // see [RULE15]
                        end
                     end
                     BY_DATA: begin
                        n.step = ST_STOP;
                     end
                     BY_RADDR: begin
                        n.step = ST_RXBYTE;
                     end
                  endcase
               end
            end
            ST_RXBYTE: begin
               n.shreg  = {r.shreg[6:0], rsp.rx};        // see [RULE16]
               n.bitcnt = r.bitcnt + 3'h1;
               if (r.bitcnt == 3'h7) begin
                  n.step = ST_RXNACK;
               end
            end
            ST_RXNACK: begin
               // only a clean read reaches here, so data is valid
               n.data = r.shreg;                         // see [RULE12]
               n.step = ST_STOP;
            end
            ST_STOP: begin
               n.busy = 1'b0;                            // see [RULE11]
               n.step = ST_IDLE;                         // see [RULE17]
            end
            ST_IDLE: begin
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // state register

   always_ff @(posedge MCLK or negedge RESET_N) begin
      if (!RESET_N) begin
         r <= TOP_RST;
      end else begin
         r <= n;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // outputs; lines are only ever pulled low, so the level is fixed

   assign CFG_RDATA        = r.rdata;
   assign CFG_RVALID       = r.rvalid;
   assign SERIAL_TEST_MODE = r.test_mode;
   assign SDA_OUT          = r.line_lvl;
   assign SCL_OUT          = r.line_lvl;

endmodule : sbsa_top

// File: dv/sbsa_monitor.sv
// port checker for the serial bus software access top level
// assumes a bind onto sbsa_top; one clock domain, MCLK
`timescale 1ns/1ns
module sbsa_monitor
   import sbsa_pkg::*;
(
   // clock and reset
   input wire logic       MCLK,
   input wire logic       RESET_N,
   // configuration access
   input wire logic [7:0] CFG_ADDR,
   input wire logic       CFG_WR,
   input wire logic       CFG_RD,
   input wire logic [7:0] CFG_RDATA,
   input wire logic       CFG_RVALID,
   // chip status
   input wire logic       DOWNLOAD_BUSY,
   input wire logic       SERIAL_TEST_MODE,
   // line drivers
   input wire logic       SDA_OUT,
   input wire logic       SDA_OE_N,
   input wire logic       SCL_OUT,
   input wire logic       SCL_OE_N
);
   default clocking @(posedge MCLK); endclocking
   default disable iff (!RESET_N);

   ////////////////////////////////////////////////////////////////////////
   // released cycles; mid-transfer both lines stay up far fewer than 15
   logic [3:0] idle_cnt_reg;
   logic       idle_long;
   logic       tgt_wr;
   logic       ctl_rd;
   assign idle_long = idle_cnt_reg == 4'hf;
   assign tgt_wr = CFG_WR && CFG_ADDR == OFS_TARGET && !DOWNLOAD_BUSY;
   assign ctl_rd = CFG_RD && CFG_ADDR == OFS_CTRL;
   always_ff @(posedge MCLK or negedge RESET_N)
      if (!RESET_N) idle_cnt_reg <= 4'h0;
      else if (!(SCL_OE_N && SDA_OE_N)) idle_cnt_reg <= 4'h0;
      else if (!idle_long) idle_cnt_reg <= idle_cnt_reg + 4'h1;

   ////////////////////////////////////////////////////////////////////////
   rd_answer_a:
      assert property (CFG_RD |=> CFG_RVALID) else $error("read unanswered");
   rv_single_a:
      assert property (!CFG_RD |=> !CFG_RVALID) else $error("stray answer");
   rdata_hold_a:
      assert property (!CFG_RD |=> $stable(CFG_RDATA))
         else $error("read data moved between reads");
   unmapped_zero_a:
      assert property (CFG_RD && CFG_ADDR[7:2] != 6'h2c |=> CFG_RDATA == 8'h00)
         else $error("unmapped offset not zero");
   ctl_fields_a:
      assert property (ctl_rd |=> !CFG_RDATA[6] && !CFG_RDATA[0] &&
         CFG_RDATA[CS_DL_BUSY] == $past(DOWNLOAD_BUSY))
         else $error("control byte fields wrong");
   test_copy_a:
      assert property (ctl_rd && !CFG_WR |=>
         CFG_RDATA[CS_TEST] == SERIAL_TEST_MODE)
         else $error("test output differs from bit 2");
   busy_shown_a:
      assert property (ctl_rd && !SCL_OE_N |=> CFG_RDATA[CS_REQ_BUSY])
         else $error("busy clear while clock held low");
   busy_clear_a:
      // lines stay released for two cycles after a launching write
      assert property (ctl_rd && idle_long && SCL_OE_N && SDA_OE_N &&
         !$past(CFG_WR) && !$past(CFG_WR, 2) |=>
         !CFG_RDATA[CS_REQ_BUSY]) else $error("busy set on idle bus");
   start_launch_a:
      assert property (tgt_wr && idle_long |-> ##[1:3] (!SCL_OE_N || !SDA_OE_N))
         else $error("target write did not launch");
   only_target_a:
      assert property (idle_long && !(SCL_OE_N && SDA_OE_N) |->
         $past(tgt_wr, 3))
         else $error("bus left idle without target write");
   scl_high_a:
      assert property ($rose(SCL_OE_N) |-> SCL_OE_N [*4])
         else $error("clock high phase too short");
   stop_idle_a:
      assert property (SCL_OE_N && $past(SCL_OE_N) && $rose(SDA_OE_N) |->
         SCL_OE_N [*4]) else $error("clock moved after stop");
   drive_zero_a:
      assert property (!SDA_OUT && !SCL_OUT) else $error("drive value not 0");

   cover property (tgt_wr && idle_long);
   cover property (ctl_rd && !SCL_OE_N);
   cover property (ctl_rd ##1 CFG_RDATA[CS_ERR]);
endmodule : sbsa_monitor

// File: dv/sbsa_slave_model.sv
// behavioural two-wire byte slave with a 256 byte store and pointer
// assumes wires pulled high; second byte after a write address sets
// the pointer, so a dropped word byte shows up as wrong read data
`timescale 1ns/1ns
module sbsa_slave_model #(
   parameter logic [6:0] DEV_ADDR = 7'h52
) (
   // wire levels
   input  wire logic scl,
   input  wire logic sda,
   // low pulls the data wire low
   output logic      sda_oe_n
);
   logic [7:0] mem [256];
   logic [7:0] shreg;
   logic [7:0] ptr;
   logic       act;
   logic       rd;
   int         nbit;
   int         nbyte;

   initial begin
      sda_oe_n = 1'b1;
      {act, rd, ptr, shreg, nbit, nbyte} = '0;
      for (int i = 0; i < 256; i++) mem[i] = 8'(i) ^ 8'h5a;
   end

   ////////////////////////////////////////////////////////////////////////
   // the start's own falling clock edge is counted too, hence -1
   always @(negedge sda) if (scl === 1'b1) begin
      {act, rd} = 2'b10;
      nbit = -1;
      nbyte = 0;
   end
   always @(posedge sda) if (scl === 1'b1) act = 1'b0;

   always @(posedge scl) if (act) begin
      if (rd && nbyte > 0) begin
         if (nbit == 8) begin
            ptr = ptr + 8'h01;
            act = !sda;
         end
      end else if (nbit < 8) shreg = {shreg[6:0], sda};
   end

   // changes only while the clock is low
   always @(negedge scl) if (act) begin
      nbit = nbit + 1;
      sda_oe_n = 1'b1;
      if (nbit == 8 && !(rd && nbyte > 0)) begin
         if (nbyte == 0) begin
            act = shreg[7:1] == DEV_ADDR;
            rd = shreg[0];
         end else if (nbyte == 1) ptr = shreg;
         else begin
            mem[ptr] = shreg;
            ptr = ptr + 8'h01;
         end
         sda_oe_n = !act;
      end else if (nbit == 9) begin
         nbit = 0;
         nbyte = nbyte + 1;
      end
      if (act && rd && nbyte > 0 && nbit < 8)
         sda_oe_n = mem[ptr][7 - nbit];
   end
endmodule : sbsa_slave_model

// File: dv/tb_sbsa_top.sv
// self-checking bench for the serial bus software access block
// assumes the slave model on the wires and the monitor bound below
`timescale 1ns/1ns
module tb_sbsa_top
   import sbsa_pkg::*;
;
   localparam logic [6:0] SLV = 7'h52;
   logic       MCLK, RESET_N, CFG_WR, CFG_RD, CFG_RVALID, SERIAL_TEST_MODE;
   logic       INTERFACE_PRESENT, DOWNLOAD_BUSY, SDA_OUT, SDA_OE_N;
   logic       SCL_OUT, SCL_OE_N, slv_oe_n;
   logic [7:0] CFG_ADDR, CFG_WDATA, CFG_RDATA, rd_byte, ptr;
   logic [7:0] mirror [256];
   wire        sda_wire = SDA_OE_N & slv_oe_n;
   int         num_errors = 0;
   int         tests_run = 0;

   sbsa_top i_dut (.MCLK(MCLK), .RESET_N(RESET_N), .CFG_ADDR(CFG_ADDR),
      .CFG_WR(CFG_WR), .CFG_WDATA(CFG_WDATA), .CFG_RD(CFG_RD),
      .CFG_RDATA(CFG_RDATA), .CFG_RVALID(CFG_RVALID),
      .INTERFACE_PRESENT(INTERFACE_PRESENT), .DOWNLOAD_BUSY(DOWNLOAD_BUSY),
      .SERIAL_TEST_MODE(SERIAL_TEST_MODE), .SDA_IN(sda_wire),
      .SDA_OUT(SDA_OUT), .SDA_OE_N(SDA_OE_N), .SCL_OUT(SCL_OUT),
      .SCL_OE_N(SCL_OE_N));
   sbsa_slave_model #(.DEV_ADDR(SLV)) i_slave (.scl(SCL_OE_N),
      .sda(sda_wire), .sda_oe_n(slv_oe_n));

   initial begin
      MCLK = 1'b0;
      forever #20 MCLK = ~MCLK;
   end

   ////////////////////////////////////////////////////////////////////////
   task automatic test_done();
      if (num_errors == 0 && tests_run > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : test_done

   task automatic check(string what, logic [7:0] exp, logic [7:0] got);
      tests_run++;
      if (got !== exp) begin
         num_errors++;
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
      end
   endtask : check

   task automatic wr(logic [7:0] a, logic [7:0] d);
      @(negedge MCLK);
      CFG_ADDR = a;
      CFG_WDATA = d;
      CFG_WR = 1'b1;
      @(negedge MCLK);
      CFG_WR = 1'b0;
   endtask : wr

   task automatic rd(logic [7:0] a);
      @(negedge MCLK);
      CFG_ADDR = a;
      CFG_RD = 1'b1;
      @(negedge MCLK);
      CFG_RD = 1'b0;
      check("read valid", 8'h01, {7'h0, CFG_RVALID});
      rd_byte = CFG_RDATA;
   endtask : rd

   // slave pointer moves as the documented byte formats dictate
   function automatic logic [7:0] expect_op(logic rw, ps, logic [7:0] w, d);
      logic [7:0] r;
      if (!ps) ptr = w;
      r = rw ? mirror[ptr] : d;
      if (!rw && ps) ptr = d;
      else begin
         if (!rw) mirror[ptr] = d;
         ptr = ptr + 8'h01;
      end
      return r;
   endfunction : expect_op

   // one software access; final control byte left in rd_byte
   task automatic xfer(logic [6:0] sa, logic rw, ps, logic [7:0] w, d);
      int n;
      repeat (20) @(negedge MCLK);
      rd(OFS_CTRL);
      check("ready status", 8'h08, rd_byte & 8'h38);
      wr(OFS_CTRL, {ps, 7'h02});
      wr(OFS_WORD, w);
      wr(OFS_DATA, d);
      wr(OFS_TARGET, {sa, rw});
      rd(OFS_CTRL);
      check("busy at launch", 8'h20, rd_byte & 8'h20);
      wr(OFS_WORD, ~w);
      n = 0;
      while (rd_byte[CS_REQ_BUSY] === 1'b1 && n < 400) begin
         rd(OFS_CTRL);
         n++;
      end
      check("busy cleared", 8'h00, rd_byte & 8'h20);
   endtask : xfer

   task automatic run(logic rw, ps, logic [7:0] w, d);
      logic [7:0] e;
      e = expect_op(rw, ps, w, d);
      xfer(SLV, rw, ps, w, d);
      check("error flag", 8'h00, rd_byte & 8'h02);
      rd(OFS_DATA);
      check("data register", e, rd_byte);
      rd(OFS_WORD);
      check("word register", w, rd_byte);
      rd(OFS_TARGET);
      check("target register", {SLV, rw}, rd_byte);
   endtask : run

   ////////////////////////////////////////////////////////////////////////
   initial begin
      {CFG_WR, CFG_RD, DOWNLOAD_BUSY, RESET_N, CFG_ADDR, CFG_WDATA} = '0;
      INTERFACE_PRESENT = 1'b1;
      ptr = 8'h00;
      for (int i = 0; i < 256; i++) mirror[i] = 8'(i) ^ 8'h5a;
      void'($urandom(32'h5f0cc031));
      repeat (3) @(negedge MCLK);
      RESET_N = 1'b1;
      for (int i = 0; i < 5; i++) begin
         rd(8'hb0 + 8'(i));
         check("reset value", i == 3 ? 8'h08 : 8'h00, rd_byte);
      end
      wr(OFS_CTRL, 8'hff);
      rd(OFS_CTRL);
      check("control bits", 8'h8c, rd_byte);
      check("test output", 8'h01, {7'h0, SERIAL_TEST_MODE});
      wr(OFS_CTRL, 8'h00);
      DOWNLOAD_BUSY = 1'b1;
      wr(OFS_TARGET, {SLV, 1'b1});
      rd(OFS_CTRL);
      check("download blocks", 8'h10, rd_byte & 8'h30);
      rd(OFS_TARGET);
      check("target kept", 8'h00, rd_byte);
      DOWNLOAD_BUSY = 1'b0;
      run(1'b0, 1'b0, 8'h00, 8'ha5);
      run(1'b1, 1'b0, 8'hff, 8'h00);
      run(1'b1, 1'b0, 8'h00, 8'h11);
      run(1'b0, 1'b1, 8'h77, 8'h00);
      run(1'b1, 1'b1, 8'h33, 8'hc3);
      xfer(SLV ^ 7'h01, 1'b1, 1'b0, 8'h10, 8'h3c);
      check("nack error", 8'h02, rd_byte & 8'h02);
      rd(OFS_DATA);
      check("data kept", 8'h3c, rd_byte);
      wr(OFS_CTRL, 8'h02);
      rd(OFS_CTRL);
      check("error cleared", 8'h00, rd_byte & 8'h02);
      for (int i = 0; i < 6; i++)
         run(1'($urandom), 1'($urandom), 8'($urandom), 8'($urandom));
      test_done();
   end

   // a full access is under 900 cycles; the twelve run here fit well inside
   initial begin
      #1000000;
      num_errors++;
      test_done();
   end
endmodule : tb_sbsa_top

bind sbsa_top sbsa_monitor i_mon (.MCLK(MCLK), .RESET_N(RESET_N),
   .CFG_ADDR(CFG_ADDR), .CFG_WR(CFG_WR), .CFG_RD(CFG_RD),
   .CFG_RDATA(CFG_RDATA), .CFG_RVALID(CFG_RVALID),
   .DOWNLOAD_BUSY(DOWNLOAD_BUSY), .SERIAL_TEST_MODE(SERIAL_TEST_MODE),
   .SDA_OUT(SDA_OUT), .SDA_OE_N(SDA_OE_N), .SCL_OUT(SCL_OUT),
   .SCL_OE_N(SCL_OE_N));
